//--- design/sci_pkg.sv
package sci_pkg;
	// Core clock and serial clock half period
	localparam int CLK_PERIOD_NS = 25;
	localparam int SCK_HALF_NS = 100;
	localparam int SCK_HALF_CYC = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Strap settling time after reset release
	localparam int STARTUP_CYC = 3;
	// Byte and slave frame layout
	localparam int BYTE_BITS = 8;
	localparam int SLV_ADDR_W = 7;
	localparam int SLV_RW_BIT = 7;
	localparam logic [4:0] SLV_ADDR_LAST = 5'h07;
	localparam logic [4:0] SLV_DATA_FIRST = 5'h08;
	localparam logic [4:0] SLV_SHIFT_FIRST = 5'h09;
	localparam logic [4:0] SLV_FRAME_LAST = 5'h0F;
	localparam logic [4:0] SLV_FRAME_BITS = 5'h10;
	// Boot fetch, receive buffer depth and engine states
	localparam logic [1:0] BOOT_CFG_SERIAL = 2'h1;
	localparam logic [7:0] MEM_READ_CMD = 8'h03;
	localparam int BOOT_HDR_BYTES = 4;
	localparam logic [7:0] FILL_BYTE = 8'h00;
	localparam int BUF_DEPTH = 2;
	typedef enum logic [2:0] {
		ST_INIT = 3'b000,
		ST_IDLE = 3'b001,
		ST_MSTR = 3'b011,
		ST_SLV = 3'b010,
		ST_BOOT = 3'b100
	} sci_state_t;
endpackage

//--- design/sci_port.sv
`timescale 1ns/1ps
module sci_port #(
	parameter int CLK_HALF = sci_pkg::SCK_HALF_CYC,
	parameter int BOOT_LEN = 256,
	parameter logic [23:0] BOOT_ADDR = 24'h00_0000
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Role control
	input wire logic masterEnable,
	input wire logic [1:0] cpuBootConfig,
	output logic bootActive,
	output logic bootDone,
	// Serial clock pin
	input wire logic portClkIn,
	output logic portClkOut,
	output logic portClkOeN,
	// Serial data pins
	input wire logic portDataIn,
	output logic portDataOut,
	output logic portDataOeN,
	// Select pin
	input wire logic portSelectNIn,
	output logic portSelectNOut,
	output logic portSelectNOeN,
	// Master framing
	input wire logic cfgLsbFirst,
	input wire logic cfgClkIdleHigh,
	// Master transmit
	input wire logic [7:0] txData,
	input wire logic txValid,
	input wire logic txLast,
	output logic txReady,
	// Received bytes
	output logic [7:0] rxData,
	output logic rxValid,
	input wire logic rxReady,
	// Register access in slave role
	output logic [sci_pkg::SLV_ADDR_W-1:0] regAddr,
	output logic [7:0] regWrData,
	output logic regWrStrobe,
	output logic regRdStrobe,
	input wire logic [7:0] regRdData
);
	import sci_pkg::*;

	localparam int DIV_W = $clog2(CLK_HALF + 1);
	localparam int IDX_W = $clog2(BOOT_LEN + BOOT_HDR_BYTES + 1);
	localparam logic [IDX_W-1:0] BOOT_HDR = IDX_W'(BOOT_HDR_BYTES);
	localparam logic [IDX_W-1:0] BOOT_END = IDX_W'(BOOT_HDR_BYTES + BOOT_LEN);
	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(CLK_HALF - 1);

	if (CLK_HALF < 1 || BOOT_LEN < 1) begin : g_bad_param
		$error("sci_port: CLK_HALF and BOOT_LEN must be at least 1");
	end

	function automatic logic [7:0] boot_byte(input logic [IDX_W-1:0] idx);
		case (idx)
			IDX_W'(0): boot_byte = MEM_READ_CMD;
			IDX_W'(1): boot_byte = BOOT_ADDR[23:16];
			IDX_W'(2): boot_byte = BOOT_ADDR[15:8];
			IDX_W'(3): boot_byte = BOOT_ADDR[7:0];
			default: boot_byte = FILL_BYTE;
		endcase
	endfunction

	// Pin synchronisers: clock, data, select, boot straps
	logic [4:0] meta_q, sync_q;
	logic sckLast_q;
	logic sckS, dinS, csnS, sckRise, sckFall;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			meta_q <= 5'h1F;
			sync_q <= 5'h1F;
			sckLast_q <= 1'b1;
		end else begin
			meta_q <= {cpuBootConfig, portSelectNIn, portDataIn, portClkIn};
			sync_q <= meta_q;
			sckLast_q <= sync_q[0];
		end
	end
	assign sckS = sync_q[0];
	assign dinS = sync_q[1];
	assign csnS = sync_q[2];
	assign sckRise = sckS & ~sckLast_q;
	assign sckFall = ~sckS & sckLast_q;

	// Two-entry receive buffer
	logic [7:0] mem_q [BUF_DEPTH];
	logic [7:0] mem_d [BUF_DEPTH];
	logic wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
	logic [1:0] bufCnt_q, bufCnt_d;
	logic bufPush, bufSpace;
	logic [7:0] bufPushData;

	// Master and boot engine
	sci_state_t state_q, state_d;
	logic [1:0] startCnt_q, startCnt_d;
	logic [DIV_W-1:0] divCnt_q, divCnt_d;
	logic [7:0] shift_q, shift_d, shiftIn;
	logic [2:0] bitCnt_q, bitCnt_d;
	logic [IDX_W-1:0] bootIdx_q, bootIdx_d;
	logic busy_q, busy_d, sck_q, sck_d, samp_q, samp_d;
	logic csN_q, csN_d, last_q, last_d, bootDone_q, bootDone_d;
	logic tick, lsbEff, txStart, drivesPins;

	assign bufSpace = bufCnt_q < 2'(BUF_DEPTH);
	assign tick = busy_q && divCnt_q == DIV_LAST;
	assign lsbEff = cfgLsbFirst && state_q == ST_MSTR;
	assign shiftIn = lsbEff ? {samp_q, shift_q[7:1]} : {shift_q[6:0], samp_q};
	assign txStart = state_q == ST_MSTR && !busy_q && txValid && bufSpace;
	assign txReady = state_q == ST_MSTR && !busy_q && bufSpace;

	always_comb begin
		state_d = state_q;
		startCnt_d = startCnt_q;
		shift_d = shift_q;
		bitCnt_d = bitCnt_q;
		bootIdx_d = bootIdx_q;
		busy_d = busy_q;
		sck_d = sck_q;
		samp_d = samp_q;
		csN_d = csN_q;
		last_d = last_q;
		bootDone_d = bootDone_q;
		bufPush = 1'b0;
		bufPushData = shiftIn;
		divCnt_d = (busy_q && !tick) ? divCnt_q + 1'b1 : '0;
		case (state_q)
			ST_INIT: begin
				// Straps are read only once the synchronisers have settled
				if (startCnt_q == 2'(STARTUP_CYC - 1)) begin
					if (sync_q[4:3] == BOOT_CFG_SERIAL) begin
						state_d = ST_BOOT;
						csN_d = 1'b0;
					end else begin
						state_d = ST_IDLE;
					end
				end else begin
					startCnt_d = startCnt_q + 1'b1;
				end
			end
			ST_BOOT: begin
				if (!busy_q && bootIdx_q == BOOT_END) begin
					csN_d = 1'b1;
					bootDone_d = 1'b1;
					state_d = ST_IDLE;
				end else if (!busy_q && bufSpace) begin
					shift_d = boot_byte(bootIdx_q);
					busy_d = 1'b1;
				end
			end
			ST_IDLE: begin
				if (masterEnable) begin
					state_d = ST_MSTR;
				end else if (!csnS) begin
					state_d = ST_SLV;
				end
			end
			ST_MSTR: begin
				if (txStart) begin
					shift_d = txData;
					busy_d = 1'b1;
					csN_d = 1'b0;
					last_d = txLast;
				end else if (!busy_q && csN_q && !masterEnable) begin
					state_d = ST_IDLE;
				end
			end
			ST_SLV: begin
				if (csnS) begin
					state_d = ST_IDLE;
				end
			end
			default: state_d = ST_IDLE;
		endcase
		// Mode 0 framing: sample on the rising edge, shift on the falling edge
		if (tick) begin
			if (!sck_q) begin
				sck_d = 1'b1;
				samp_d = dinS;
			end else begin
				sck_d = 1'b0;
				shift_d = shiftIn;
				bitCnt_d = bitCnt_q + 1'b1;
				if (bitCnt_q == 3'(BYTE_BITS - 1)) begin
					busy_d = 1'b0;
					bufPush = state_q == ST_MSTR || bootIdx_q >= BOOT_HDR;
					if (state_q == ST_BOOT) begin
						bootIdx_d = bootIdx_q + 1'b1;
					end
					if (state_q == ST_MSTR && last_q) begin
						csN_d = 1'b1;
					end
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_q <= ST_INIT;
			startCnt_q <= '0;
			divCnt_q <= '0;
			shift_q <= 8'h00;
			bitCnt_q <= '0;
			bootIdx_q <= '0;
			busy_q <= 1'b0;
			sck_q <= 1'b0;
			samp_q <= 1'b0;
			csN_q <= 1'b1;
			last_q <= 1'b0;
			bootDone_q <= 1'b0;
		end else begin
			state_q <= state_d;
			startCnt_q <= startCnt_d;
			divCnt_q <= divCnt_d;
			shift_q <= shift_d;
			bitCnt_q <= bitCnt_d;
			bootIdx_q <= bootIdx_d;
			busy_q <= busy_d;
			sck_q <= sck_d;
			samp_q <= samp_d;
			csN_q <= csN_d;
			last_q <= last_d;
			bootDone_q <= bootDone_d;
		end
	end

	always_comb begin
		mem_d = mem_q;
		wrPtr_d = wrPtr_q;
		rdPtr_d = rdPtr_q;
		bufCnt_d = bufCnt_q;
		if (bufPush) begin
			mem_d[wrPtr_q] = bufPushData;
			wrPtr_d = ~wrPtr_q;
		end
		if (rxValid && rxReady) begin
			rdPtr_d = ~rdPtr_q;
		end
		bufCnt_d = bufCnt_q + {1'b0, bufPush} - {1'b0, rxValid && rxReady};
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			mem_q <= '{default: 8'h00};
			wrPtr_q <= 1'b0;
			rdPtr_q <= 1'b0;
			bufCnt_q <= '0;
		end else begin
			mem_q <= mem_d;
			wrPtr_q <= wrPtr_d;
			rdPtr_q <= rdPtr_d;
			bufCnt_q <= bufCnt_d;
		end
	end
	assign rxValid = bufCnt_q != 2'h0;
	assign rxData = mem_q[rdPtr_q];

	// Slave engine: byte 0 is read flag and address, byte 1 is data
	logic [4:0] slvCnt_q, slvCnt_d;
	logic [7:0] slvSh_q, slvSh_d, slvTx_q, slvTx_d, slvShNext, wrData_q, wrData_d;
	logic [SLV_ADDR_W-1:0] addr_q, addr_d;
	logic isRead_q, isRead_d, rdStb_q, rdStb_d, wrStb_q, wrStb_d, slvActive, slvDrive;

	assign slvActive = state_q == ST_SLV && !csnS;
	assign slvShNext = {slvSh_q[6:0], dinS};

	always_comb begin
		slvCnt_d = slvCnt_q;
		slvSh_d = slvSh_q;
		slvTx_d = slvTx_q;
		wrData_d = wrData_q;
		addr_d = addr_q;
		isRead_d = isRead_q;
		rdStb_d = 1'b0;
		wrStb_d = 1'b0;
		if (!slvActive) begin
			// Select high ends any frame, partial or not
			slvCnt_d = '0;
			isRead_d = 1'b0;
		end else if (sckRise && slvCnt_q != SLV_FRAME_BITS) begin
			slvCnt_d = slvCnt_q + 1'b1;
			slvSh_d = slvShNext;
			if (slvCnt_q == SLV_ADDR_LAST) begin
				isRead_d = slvShNext[SLV_RW_BIT];
				addr_d = slvShNext[SLV_ADDR_W-1:0];
				rdStb_d = slvShNext[SLV_RW_BIT];
			end
			if (slvCnt_q == SLV_FRAME_LAST && !isRead_q) begin
				wrData_d = slvShNext;
				wrStb_d = 1'b1;
			end
		end
		if (rdStb_q) begin
			slvTx_d = regRdData;
		end else if (slvActive && sckFall && slvCnt_q >= SLV_SHIFT_FIRST) begin
			slvTx_d = {slvTx_q[6:0], 1'b0};
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			slvCnt_q <= '0;
			slvSh_q <= 8'h00;
			slvTx_q <= 8'h00;
			wrData_q <= 8'h00;
			addr_q <= '0;
			isRead_q <= 1'b0;
			rdStb_q <= 1'b0;
			wrStb_q <= 1'b0;
		end else begin
			slvCnt_q <= slvCnt_d;
			slvSh_q <= slvSh_d;
			slvTx_q <= slvTx_d;
			wrData_q <= wrData_d;
			addr_q <= addr_d;
			isRead_q <= isRead_d;
			rdStb_q <= rdStb_d;
			wrStb_q <= wrStb_d;
		end
	end

	// Pin drivers; slave output tracks a flop so it lands before the next rising edge
	assign drivesPins = state_q == ST_MSTR || state_q == ST_BOOT;
	assign slvDrive = slvActive && isRead_q && slvCnt_q >= SLV_DATA_FIRST;
	assign portClkOut = sck_q ^ (cfgClkIdleHigh && state_q == ST_MSTR);
	assign portClkOeN = !drivesPins;
	assign portSelectNOut = csN_q;
	assign portSelectNOeN = !drivesPins;
	assign portDataOut = (state_q == ST_SLV) ? slvTx_q[7] : (lsbEff ? shift_q[0] : shift_q[7]);
	assign portDataOeN = !(slvDrive || (drivesPins && !csN_q));
	assign bootActive = state_q == ST_BOOT;
	assign bootDone = bootDone_q;
	assign regAddr = addr_q;
	assign regWrData = wrData_q;
	assign regWrStrobe = wrStb_q;
	assign regRdStrobe = rdStb_q;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	chk_clk_dir: assert property ($changed(sck_q) |-> !portClkOeN)
		else $error("serial clock moved while undriven");
	chk_sel_input: assert property (state_q == ST_SLV |-> portSelectNOeN && portClkOeN)
		else $error("select driven in slave role");
	chk_slave_do_off: assert property (state_q == ST_SLV && csnS |-> portDataOeN)
		else $error("data driven with select high");
	chk_master_cs_low: assert property (state_q == ST_MSTR && busy_q
		|-> !portSelectNOut && !portSelectNOeN) else $error("select high during access");
	chk_boot_release: assert property ($fell(bootActive)
		|-> portSelectNOut && bootDone) else $error("select not released after boot");
	chk_boot_cmd: assert property ($rose(busy_q) && bootActive && bootIdx_q == '0
		|-> portDataOut == MEM_READ_CMD[7] && !portDataOeN)
		else $error("boot command not first");
	chk_rd_then_load: assert property (regRdStrobe
		|=> slvTx_q == $past(regRdData) && !regRdStrobe) else $error("read data not loaded");
	chk_tx_start: assert property (txValid && txReady
		|=> busy_q && !portSelectNOut && !portDataOeN) else $error("taken byte did not start");
	chk_wr_pulse: assert property (regWrStrobe
		|-> !isRead_q && slvCnt_q == SLV_FRAME_BITS) else $error("write strobe out of frame");
	chk_buf_bound: assert property (bufCnt_q <= 2'(BUF_DEPTH))
		else $error("receive buffer overflow");

	cov_boot_done: cover property ($rose(bootDone));
	cov_slave_write: cover property (regWrStrobe);
	cov_slave_read: cover property (regRdStrobe);
	cov_buf_full: cover property (bufCnt_q == 2'(BUF_DEPTH) && !rxReady);
endmodule // sci_port

//--- verif/sci_periph_model.sv
`timescale 1ns/1ps
// Far-side serial memory or peripheral; replies 8'hC0 plus the byte index
module sci_periph_model (
	// Pins seen from the far side
	input wire logic sck,
	input wire logic selN,
	input wire logic mosi,
	input wire logic idleHigh,
	output logic miso
);
	logic [7:0] shIn;
	logic [7:0] resp;
	logic [7:0] rxLog[$];
	int bitCnt;
	int byteCnt;
	wire logic effClk = sck ^ idleHigh;
	initial begin
		miso = 1'b1;
		bitCnt = 0;
		byteCnt = 0;
	end
	// Released line floats to the pull-up level
	always @(posedge selN) miso = 1'b1;
	always @(negedge selN) begin
		bitCnt = 0;
		byteCnt = 0;
		resp = 8'hC0;
		miso = resp[7];
	end
	// Sample on the leading edge
	always @(posedge effClk) if (!selN) begin
		shIn = {shIn[6:0], mosi};
		bitCnt++;
		if (bitCnt == 8) begin
			rxLog.push_back(shIn);
			bitCnt = 0;
			byteCnt++;
		end
	end
	// Reply on the trailing edge, MSB first
	always @(negedge effClk) if (!selN) begin
		resp = 8'hC0 + 8'(byteCnt);
		miso = resp[7 - bitCnt];
	end
endmodule // sci_periph_model

//--- verif/sci_port_tb.sv
`timescale 1ns/1ps
module sci_port_tb;
	import sci_pkg::*;
	localparam logic [23:0] BADDR = 24'h12_3456;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic masterEnable = 1'b0;
	logic [1:0] cpuBootConfig = BOOT_CFG_SERIAL;
	logic cfgLsbFirst = 1'b0;
	logic cfgClkIdleHigh = 1'b0;
	logic [7:0] txData = 8'h00;
	logic txValid = 1'b0;
	logic txLast = 1'b0;
	logic rxReady = 1'b0;
	logic [7:0] regRdData = 8'h96;
	logic tbSck = 1'b0;
	logic tbSelN = 1'b1;
	logic tbMosi = 1'b0;
	logic slvMode = 1'b0;
	logic bootActive, bootDone, portClkOut, portClkOeN, portDataOut, portDataOeN, miso;
	logic portSelectNOut, portSelectNOeN, txReady, rxValid, regWrStrobe, regRdStrobe;
	logic [7:0] rxData, regWrData, wrData;
	logic [6:0] regAddr, wrAddr;
	int errors = 0;
	int n_compared = 0;
	int wrCnt = 0;
	int rdCnt = 0;
	// Pin levels from the port's enables; the testbench drives clock and select when the port does not, and undriven data floats high
	wire logic sckW = !portClkOeN ? portClkOut : tbSck;
	wire logic selW = !portSelectNOeN ? portSelectNOut : tbSelN;
	wire logic doW = !portDataOeN ? portDataOut : 1'b1;
	wire logic diW = slvMode ? tbMosi : miso;
	always #12.5 clk = ~clk;
	sci_port #(.BOOT_LEN(4), .BOOT_ADDR(BADDR)) uut (.clk(clk), .rst_n(rst_n),
		.masterEnable(masterEnable), .cpuBootConfig(cpuBootConfig), .bootActive(bootActive),
		.bootDone(bootDone), .portClkIn(sckW), .portClkOut(portClkOut), .portClkOeN(portClkOeN),
		.portDataIn(diW), .portDataOut(portDataOut), .portDataOeN(portDataOeN),
		.portSelectNIn(selW), .portSelectNOut(portSelectNOut), .portSelectNOeN(portSelectNOeN),
		.cfgLsbFirst(cfgLsbFirst), .cfgClkIdleHigh(cfgClkIdleHigh), .txData(txData),
		.txValid(txValid), .txLast(txLast), .txReady(txReady), .rxData(rxData), .rxValid(rxValid),
		.rxReady(rxReady), .regAddr(regAddr), .regWrData(regWrData), .regWrStrobe(regWrStrobe),
		.regRdStrobe(regRdStrobe), .regRdData(regRdData));
	sci_periph_model far (.sck(sckW), .selN(selW), .mosi(doW), .idleHigh(cfgClkIdleHigh),
		.miso(miso));
	always @(posedge clk) begin
		if (regWrStrobe === 1'b1) begin
			wrCnt++;
			wrAddr = regAddr;
			wrData = regWrData;
		end
		if (regRdStrobe === 1'b1) rdCnt++;
	end
	task automatic summarize;
		if (errors == 0 && n_compared > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chkb(input logic got, input logic exp);
		chk({7'h00, got}, {7'h00, exp});
	endtask
	task automatic waitc(input int n);
		repeat (n) @(posedge clk);
	endtask
	// Bounded wait; a hang counts as a mismatch
	task automatic waitSig(ref logic s, input logic v);
		int n;
		n = 0;
		while (s !== v && n < 3000) begin
			@(posedge clk);
			#1;
			n++;
		end
		chkb(s, v);
	endtask
	task automatic popChk(input logic [7:0] exp);
		waitSig(rxValid, 1'b1);
		chk(rxData, exp);
		@(posedge clk) rxReady <= 1'b1;
		@(posedge clk) rxReady <= 1'b0;
		#1;
	endtask
	task automatic sendByte(input logic [7:0] d, input logic last);
		waitSig(txReady, 1'b1);
		@(posedge clk);
		txData <= d;
		txValid <= 1'b1;
		txLast <= last;
		@(posedge clk) txValid <= 1'b0;
		#1;
	endtask
	task automatic slvFrame(input logic selLvl, input logic [15:0] f, output logic [7:0] got);
		@(posedge clk) tbSelN <= selLvl;
		waitc(8);
		for (int i = 0; i < 16; i++) begin
			tbMosi <= f[15-i];
			waitc(4);
			tbSck <= 1'b1;
			if (i >= 8) got[15-i] = doW;
			waitc(4);
			tbSck <= 1'b0;
		end
		waitc(4);
		tbSelN <= 1'b1;
		waitc(8);
	endtask
	task automatic bootTest;
		logic [7:0] exp[8];
		exp = '{MEM_READ_CMD, BADDR[23:16], BADDR[15:8], BADDR[7:0], FILL_BYTE, FILL_BYTE,
			FILL_BYTE, FILL_BYTE};
		// Sink stalls long enough that an unstalled fetch would have ended
		waitc(600);
		chkb(bootActive, 1'b1);
		chkb(selW, 1'b0);
		chkb(portClkOeN, 1'b0);
		for (int k = 4; k < 8; k++) popChk(8'hC0 + 8'(k));
		waitSig(bootDone, 1'b1);
		waitc(2);
		chkb(selW, 1'b1);
		chkb(portDataOeN, 1'b1);
		chk(8'(far.rxLog.size()), 8'h08);
		for (int k = 0; k < 8; k++) chk(far.rxLog[k], exp[k]);
		far.rxLog.delete();
	endtask
	task automatic slaveTest;
		logic [7:0] g;
		@(posedge clk) slvMode <= 1'b1;
		waitc(2);
		chkb(portDataOeN, 1'b1);
		chkb(portClkOeN, 1'b1);
		slvFrame(1'b1, 16'h155A, g);
		chk(8'(wrCnt), 8'h00);
		slvFrame(1'b0, 16'h155A, g);
		chk(8'(wrCnt), 8'h01);
		chk({1'b0, wrAddr}, 8'h15);
		chk(wrData, 8'h5A);
		slvFrame(1'b0, 16'hABFF, g);
		chk(8'(rdCnt), 8'h01);
		chk(g, 8'h96);
		chk({1'b0, regAddr}, 8'h2B);
		chk(8'(wrCnt), 8'h01);
		chkb(portDataOeN, 1'b1);
		// The far model listens on the same pins, so it logged both selected frames
		chk(8'(far.rxLog.size()), 8'h04);
		chk(far.rxLog[1], 8'hFF);
		chk(far.rxLog[3], 8'h96);
		far.rxLog.delete();
	endtask
	task automatic masterTest;
		@(posedge clk);
		slvMode <= 1'b0;
		masterEnable <= 1'b1;
		waitc(4);
		sendByte(8'hA5, 1'b0);
		waitc(30);
		chkb(selW, 1'b0);
		chkb(portClkOeN, 1'b0);
		sendByte(8'h3C, 1'b1);
		waitc(2);
		waitSig(portSelectNOut, 1'b1);
		chkb(txReady, 1'b0);
		popChk(8'hC0);
		popChk(8'hC1);
		chk(far.rxLog[0], 8'hA5);
		chk(far.rxLog[1], 8'h3C);
		// Reversed order and inverted clock idle
		@(posedge clk);
		cfgLsbFirst <= 1'b1;
		cfgClkIdleHigh <= 1'b1;
		sendByte(8'h01, 1'b1);
		waitc(2);
		waitSig(portSelectNOut, 1'b1);
		waitc(2);
		chkb(sckW, 1'b1);
		popChk(8'h03);
		chk(far.rxLog[2], 8'h80);
	endtask
	initial begin
		waitc(20);
		rst_n <= 1'b1;
		bootTest();
		@(posedge clk);
		rst_n <= 1'b0;
		cpuBootConfig <= 2'h0;
		waitc(20);
		rst_n <= 1'b1;
		waitc(8);
		slaveTest();
		masterTest();
		summarize();
	end
	// About fourteen times the expected run
	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		$display("[ERR] %0t watchdog expired", $time);
		summarize();
	end
endmodule // sci_port_tb
